// ==== serial_port_pkg.sv ====
package serial_port_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [15:0] IDX_RX_DATA = 16'h1FB8;
  localparam logic [15:0] IDX_STATUS = 16'h1FB9;
  localparam logic [15:0] IDX_TX_DATA = 16'h1FBA;
  localparam logic [15:0] IDX_CONFIG = 16'h1FBB;
  localparam logic [15:0] IDX_BAUD = 16'h1FBC;
  localparam logic [15:0] ADDR_RX_DATA = {IDX_RX_DATA[13:0], 2'b00};
  localparam logic [15:0] ADDR_STATUS = {IDX_STATUS[13:0], 2'b00};
  localparam logic [15:0] ADDR_TX_DATA = {IDX_TX_DATA[13:0], 2'b00};
  localparam logic [15:0] ADDR_CONFIG = {IDX_CONFIG[13:0], 2'b00};
  localparam logic [15:0] ADDR_BAUD = {IDX_BAUD[13:0], 2'b00};

  // serial_config fields
  localparam int CFG_ODD_PARITY = 5;
  localparam int CFG_NINTH = 4;
  localparam int CFG_RX_ENABLE = 3;
  localparam int CFG_PARITY_EN = 2;
  localparam int CFG_MODE_HI = 1;
  localparam int CFG_MODE_LO = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // rate_divider fields
  localparam int BAUD_CLKSEL = 15;
  localparam int BAUD_DIV_HI = 14;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  // serial_flags: bit 7 parity error/ninth, 6 rx done, 5 tx done,
  // 4 framing error, 3 tx empty, 2 overrun, 1:0 undefined (read as ones)
  localparam logic [7:0] STATUS_RESET = 8'h0B;
  localparam logic [1:0] STATUS_LOW_BITS = 2'b11;

  localparam logic [1:0] MODE_SYNC = 2'b00;
  localparam logic [1:0] MODE_ASYNC8 = 2'b01;
  localparam logic [1:0] MODE_ASYNC9 = 2'b10;
  localparam logic [1:0] MODE_ASYNC9P = 2'b11;

  // generator pulses per bit: internal source divides by (div+1);
  // external source counts both clock edges, so div edges = div/2 periods
  localparam logic [3:0] SUB_LAST_SYNC = 4'h1;
  localparam logic [3:0] SUB_LAST_ASYNC = 4'hF;
  localparam logic [3:0] SUB_MID_ASYNC = 4'h7;
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [3:0] BITS_ASYNC8 = 4'hA;
  localparam logic [3:0] BITS_ASYNC9 = 4'hB;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_e;

endpackage

// ==== serial_port_control.sv ====
`timescale 1ns/100ps

module serial_port_control
  import serial_port_pkg::*;
(
  input wire logic hclk, // bus and oscillator clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic hsel, // slave select
  input wire logic [15:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always OKAY
  input wire logic rxd_in, // receive data pin level
  output logic rxd_out, // receive pin drive level in mode 0
  output logic rxd_oe, // receive pin driven low in mode 0
  output logic txd_out, // transmit data, or shift clock in mode 0
  input wire logic external_clock_input // external generator clock pin
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic [1:0] mode;
    logic ren;
    logic parity_enable;
    logic tb8;
    logic par;
    logic baud_sel;
    logic [14:0] baud_div;
    logic [14:0] gen_cnt;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_s3;
    logic rxd_f;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_f;
    logic rb8;
    logic ri;
    logic ti;
    logic fe;
    logic oe;
    tx_state_e tx_st;
    logic [7:0] hold;
    logic hold_full;
    logic [10:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_sub;
    logic [3:0] tx_n;
    rx_state_e rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_bit;
    logic [3:0] rx_sub;
    logic [7:0] rx_buf;
    logic rx_unread;
    logic wr_pend;
    logic [15:0] wr_addr;
    logic [31:0] hrdata_q;
    logic hready_q;
    logic txd_q;
    logic rxd_oe_q;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic gen;
  logic ti_ev;
  logic ri_ev;
  logic mode_chg;
  logic wr_tx;
  logic tx_start;
  logic sync_mode;
  logic [3:0] sub_last;
  logic [3:0] sub_mid;
  logic [3:0] rx_n;
  logic tx_buffer_empty;
  logic [7:0] status;
  logic [7:0] rdat;
  logic [8:0] nsh;
  logic ninth;
  logic par_bit;
  logic perr;

  assign hrdata = s_q.hrdata_q;
  assign hreadyout = s_q.hready_q;
  assign hresp = 1'b0;
  assign rxd_out = 1'b0;
  assign rxd_oe = s_q.rxd_oe_q;
  assign txd_out = s_q.txd_q;

  always_comb begin
    s_d = s_q;
    gen = 1'b0;
    ti_ev = 1'b0;
    ri_ev = 1'b0;
    mode_chg = 1'b0;
    wr_tx = 1'b0;
    tx_start = 1'b0;
    rdat = 8'h00;
    nsh = 9'h000;
    ninth = 1'b0;
    par_bit = 1'b0;
    perr = 1'b0;
    sync_mode = (s_q.mode == MODE_SYNC);
    sub_last = sync_mode ? SUB_LAST_SYNC : SUB_LAST_ASYNC;
    sub_mid = sync_mode ? SUB_LAST_SYNC : SUB_MID_ASYNC;
    rx_n = (s_q.mode == MODE_ASYNC8 || sync_mode) ? 4'h8 : 4'h9;
    tx_buffer_empty = s_q.hold_full == 1'b0 && s_q.tx_st == TX_IDLE;
    status = {s_q.rb8, s_q.ri, s_q.ti, s_q.fe, tx_buffer_empty, s_q.oe, STATUS_LOW_BITS};

    // three-stage pin synchronisers; a level counts once stages two and three agree
    s_d.rxd_s1 = rxd_in;
    s_d.rxd_s2 = s_q.rxd_s1;
    s_d.rxd_s3 = s_q.rxd_s2;
    if (s_q.rxd_s2 == s_q.rxd_s3) begin
      s_d.rxd_f = s_q.rxd_s3;
    end
    s_d.ext_s1 = external_clock_input;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    if (s_q.ext_s2 == s_q.ext_s3) begin
      s_d.ext_f = s_q.ext_s3;
    end

    // generator: the down-counter reloads from the divider on each pulse
    if (s_q.baud_sel) begin
      if (s_q.gen_cnt == 15'h0000) begin
        gen = 1'b1;
        s_d.gen_cnt = s_q.baud_div;
      end else begin
        s_d.gen_cnt = s_q.gen_cnt - 15'h0001;
      end
    end else if (s_d.ext_f != s_q.ext_f) begin
      // both edges counted; a zero divider behaves as one
      if (s_q.gen_cnt == 15'h0000 || s_q.gen_cnt == 15'h0001) begin
        gen = 1'b1;
        s_d.gen_cnt = s_q.baud_div;
      end else begin
        s_d.gen_cnt = s_q.gen_cnt - 15'h0001;
      end
    end

    // address phase: read data is captured now, so read side effects act here
    s_d.hready_q = 1'b1;
    s_d.wr_pend = hsel && htrans[1] && hready && hwrite;
    if (hsel && htrans[1] && hready && hwrite) begin
      s_d.wr_addr = haddr;
    end
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr)
        ADDR_STATUS: begin
          rdat = status;
          s_d.rb8 = 1'b0;
          s_d.ri = 1'b0;
          s_d.ti = 1'b0;
          s_d.fe = 1'b0;
          s_d.oe = 1'b0;
        end
        ADDR_RX_DATA: begin
          rdat = s_q.rx_buf;
          s_d.rx_unread = 1'b0;
        end
        ADDR_CONFIG: rdat = {2'b00, s_q.par, s_q.tb8, s_q.ren, s_q.parity_enable, s_q.mode};
        default: rdat = 8'h00;
      endcase
      if (haddr == ADDR_BAUD) begin
        s_d.hrdata_q = {16'h0000, s_q.baud_sel, s_q.gen_cnt};
      end else begin
        s_d.hrdata_q = {24'h000000, rdat};
      end
    end

    // data phase of a write
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        ADDR_CONFIG: begin
          mode_chg = hwdata[CFG_MODE_HI:CFG_MODE_LO] != s_q.mode;
          s_d.mode = hwdata[CFG_MODE_HI:CFG_MODE_LO];
          s_d.ren = hwdata[CFG_RX_ENABLE];
          s_d.parity_enable = hwdata[CFG_PARITY_EN];
          s_d.tb8 = hwdata[CFG_NINTH];
          s_d.par = hwdata[CFG_ODD_PARITY];
        end
        ADDR_BAUD: begin
          s_d.baud_sel = hwdata[BAUD_CLKSEL];
          s_d.baud_div = hwdata[BAUD_DIV_HI:0];
          s_d.gen_cnt = hwdata[BAUD_DIV_HI:0];
        end
        ADDR_TX_DATA: begin
          wr_tx = 1'b1;
          s_d.hold = hwdata[7:0];
          s_d.hold_full = 1'b1;
        end
        default: s_d.hold_full = s_d.hold_full;
      endcase
    end

    if (mode_chg) begin
      // a new mode drops both engines and any byte waiting to go
      s_d.tx_st = TX_IDLE;
      s_d.rx_st = RX_IDLE;
      s_d.hold_full = wr_tx;
    end else begin
      // transmitter
      case (s_q.tx_st)
        TX_IDLE: begin
          if (s_q.hold_full && (!sync_mode || !s_q.ren)) begin
            tx_start = 1'b1;
            par_bit = s_q.par ? ~^s_q.hold : ^s_q.hold;
            s_d.tx_st = TX_SHIFT;
            s_d.tx_bit = 4'h0;
            s_d.tx_sub = 4'h0;
            if (!wr_tx) begin
              s_d.hold_full = 1'b0;
            end
            if (sync_mode) begin
              s_d.tx_sh = {3'b111, s_q.hold};
              s_d.tx_n = BITS_SYNC;
            end else if (s_q.mode == MODE_ASYNC8) begin
              // parity replaces the eighth data bit
              par_bit = s_q.par ? ~^s_q.hold[6:0] : ^s_q.hold[6:0];
              s_d.tx_sh = {2'b11, s_q.parity_enable ? par_bit : s_q.hold[7], s_q.hold[6:0], 1'b0};
              s_d.tx_n = BITS_ASYNC8;
            end else begin
              ninth = (s_q.parity_enable && s_q.mode == MODE_ASYNC9P) ? par_bit : s_q.tb8;
              s_d.tx_sh = {1'b1, ninth, s_q.hold, 1'b0};
              s_d.tx_n = BITS_ASYNC9;
            end
          end
        end
        TX_SHIFT: begin
          if (gen) begin
            if (s_q.tx_sub == sub_last) begin
              s_d.tx_sub = 4'h0;
              s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
              s_d.tx_bit = s_q.tx_bit + 4'h1;
              if (s_q.tx_bit == s_q.tx_n - 4'h1) begin
                s_d.tx_st = TX_IDLE;
                ti_ev = sync_mode;
              end else if (!sync_mode && s_q.tx_bit == s_q.tx_n - 4'h2) begin
                ti_ev = 1'b1;
              end
            end else begin
              s_d.tx_sub = s_q.tx_sub + 4'h1;
            end
          end
        end
        default: s_d.tx_st = TX_IDLE;
      endcase
      if (ti_ev) begin
        s_d.ti = 1'b1;
        s_d.tb8 = 1'b0;
      end

      // receiver
      if (!s_q.ren) begin
        s_d.rx_st = RX_IDLE;
      end else begin
        case (s_q.rx_st)
          RX_IDLE: begin
            if (!sync_mode && s_q.rxd_f && !s_d.rxd_f) begin
              s_d.rx_st = RX_SHIFT;
              s_d.rx_bit = 4'h0;
              s_d.rx_sub = 4'h0;
            end else if (sync_mode && !s_q.ri && s_q.tx_st == TX_IDLE) begin
              // mode 0 has no start bit; a cleared rx done flag starts the next byte
              s_d.rx_st = RX_SHIFT;
              s_d.rx_bit = 4'h1;
              s_d.rx_sub = 4'h0;
            end
          end
          RX_SHIFT: begin
            if (gen) begin
              s_d.rx_sub = (s_q.rx_sub == sub_last) ? 4'h0 : s_q.rx_sub + 4'h1;
              if (s_q.rx_sub == sub_mid) begin
                s_d.rx_bit = s_q.rx_bit + 4'h1;
                nsh = {s_q.rxd_f, s_q.rx_sh[8:1]};
                if (s_q.rx_bit == 4'h0) begin
                  if (s_q.rxd_f) begin
                    s_d.rx_st = RX_IDLE;
                  end
                end else if (s_q.rx_bit <= rx_n) begin
                  s_d.rx_sh = nsh;
                  if (s_q.rx_bit == rx_n) begin
                    ri_ev = 1'b1;
                    if (sync_mode) begin
                      s_d.rx_st = RX_IDLE;
                    end
                  end
                end else begin
                  s_d.rx_st = RX_IDLE;
                  if (!s_q.rxd_f) begin
                    s_d.fe = 1'b1;
                  end
                end
              end
            end
          end
          default: s_d.rx_st = RX_IDLE;
        endcase
      end
      if (ri_ev) begin
        rdat = (rx_n == 4'h8) ? nsh[8:1] : nsh[7:0];
        ninth = nsh[8];
        if (s_q.mode == MODE_ASYNC8) begin
          perr = (s_q.par ? ~^rdat[6:0] : ^rdat[6:0]) != rdat[7];
        end else begin
          perr = (s_q.par ? ~^rdat : ^rdat) != ninth;
        end
        // mode 2 keeps only frames whose ninth bit is set
        if (s_q.mode != MODE_ASYNC9 || ninth) begin
          s_d.ri = 1'b1;
          s_d.rx_buf = rdat;
          if (s_d.rx_unread) begin
            s_d.oe = 1'b1;
          end
          s_d.rx_unread = 1'b1;
          if (s_q.parity_enable && (s_q.mode == MODE_ASYNC8 || s_q.mode == MODE_ASYNC9P)) begin
            s_d.rb8 = perr;
          end else begin
            s_d.rb8 = (s_q.mode == MODE_ASYNC8 || sync_mode) ? 1'b0 : ninth;
          end
        end
      end
    end

    // pins: in mode 0 the transmit pin carries the shift clock, low in the first half
    if (sync_mode && (s_d.tx_st == TX_SHIFT || s_d.rx_st == RX_SHIFT)) begin
      s_d.txd_q = (s_d.tx_st == TX_SHIFT) ? (s_d.tx_sub != 4'h0) : (s_d.rx_sub != 4'h0);
    end else begin
      s_d.txd_q = (s_d.tx_st == TX_SHIFT) ? s_d.tx_sh[0] : 1'b1;
    end
    s_d.rxd_oe_q = sync_mode && s_d.tx_st == TX_SHIFT && !s_d.tx_sh[0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.mode <= CONFIG_RESET[CFG_MODE_HI:CFG_MODE_LO];
      s_q.baud_sel <= BAUD_RESET[BAUD_CLKSEL];
      s_q.baud_div <= BAUD_RESET[BAUD_DIV_HI:0];
      s_q.gen_cnt <= BAUD_RESET[BAUD_DIV_HI:0];
      s_q.rxd_s1 <= 1'b1;
      s_q.rxd_s2 <= 1'b1;
      s_q.rxd_s3 <= 1'b1;
      s_q.rxd_f <= 1'b1;
      s_q.tx_st <= TX_IDLE;
      s_q.rx_st <= RX_IDLE;
      s_q.txd_q <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  property p_mode_abort;
    @(posedge hclk) disable iff (!hresetn)
      (ce && mode_chg) |=> (s_q.tx_st == TX_IDLE && s_q.rx_st == RX_IDLE);
  endproperty
  a_mode_abort: assert property (p_mode_abort) else $error("mode change left an engine busy");

  property p_baud_read;
    @(posedge hclk) disable iff (!hresetn)
      (ce && hsel && htrans[1] && hready && !hwrite && haddr == ADDR_BAUD)
      |=> hrdata == {16'h0000, $past(s_q.baud_sel), $past(s_q.gen_cnt)};
  endproperty
  a_baud_read: assert property (p_baud_read) else $error("divider read not the counter");

  property p_status_clear;
    @(posedge hclk) disable iff (!hresetn)
      (ce && hsel && htrans[1] && hready && !hwrite && haddr == ADDR_STATUS && !ti_ev && !ri_ev)
      |=> (!s_q.ti && !s_q.ri && hrdata[3] == $past(tx_buffer_empty));
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status read did not clear");

  property p_ninth_clear;
    @(posedge hclk) disable iff (!hresetn)
      (ce && ti_ev) |=> (!s_q.tb8 && s_q.ti);
  endproperty
  a_ninth_clear: assert property (p_ninth_clear) else $error("ninth bit not cleared");

  property p_ren_stop;
    @(posedge hclk) disable iff (!hresetn)
      (ce && !s_q.ren) |=> s_q.rx_st == RX_IDLE;
  endproperty
  a_ren_stop: assert property (p_ren_stop) else $error("reception ran without enable");

  property p_sync_tx;
    @(posedge hclk) disable iff (!hresetn)
      (tx_start && s_q.mode == MODE_SYNC) |-> !s_q.ren;
  endproperty
  a_sync_tx: assert property (p_sync_tx) else $error("mode 0 send with receive enabled");

  property p_txe_write;
    @(posedge hclk) disable iff (!hresetn)
      (ce && s_q.wr_pend && s_q.wr_addr == ADDR_TX_DATA && !mode_chg) |=> !tx_buffer_empty;
  endproperty
  a_txe_write: assert property (p_txe_write) else $error("tx empty after a byte write");

  property p_parity3;
    @(posedge hclk) disable iff (!hresetn)
      (ce && tx_start && s_q.mode == MODE_ASYNC9P && s_q.parity_enable)
      |=> s_q.tx_sh[9] == ($past(s_q.par) ^ (^s_q.tx_sh[8:1]));
  endproperty
  a_parity3: assert property (p_parity3) else $error("wrong parity bit sent");

  property p_overrun;
    @(posedge hclk) disable iff (!hresetn)
      (ce && ri_ev && s_q.rx_unread && s_q.mode != MODE_ASYNC9
       && !(hsel && htrans[1] && hready && !hwrite)) |=> s_q.oe;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

endmodule

// ==== serial_remote_device.sv ====
`timescale 1ns/100ps
module serial_remote_device (
  input wire logic clk, // sampling clock
  input wire logic txd, // line from the port
  input int bit_len, // bit time in clk cycles
  input int n_bits, // data bits expected per frame
  output logic rxd // line into the port, pulled up when idle
);
  logic [8:0] shift;
  int got_q[$];

  initial rxd = 1'b1;

  // a start edge is checked again at mid bit so a glitch is not taken for a frame
  always begin
    @(negedge txd);
    repeat (bit_len / 2) @(posedge clk);
    if (txd === 1'b0) begin
      shift = '0;
      for (int i = 0; i < n_bits; i++) begin
        repeat (bit_len) @(posedge clk);
        shift[i] = txd;
      end
      repeat (bit_len) @(posedge clk);
      got_q.push_back({txd, shift});
    end
  end

  // caller enters just after a rising edge; the line returns high for one idle bit
  task automatic send_frame(input logic [8:0] d, input int n, input logic stop);
    rxd <= 1'b0;
    repeat (bit_len) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (bit_len) @(posedge clk);
    end
    rxd <= stop;
    repeat (bit_len) @(posedge clk);
    rxd <= 1'b1;
    repeat (bit_len) @(posedge clk);
  endtask
endmodule

// ==== serial_port_control_baud_status_test.sv ====
`timescale 1ns/100ps
module serial_port_control_baud_status_test;
  import serial_port_pkg::*;
  localparam int BIT_LEN = 32; // internal source, divider 1: 16 * 2 cycles
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rxd_out, rxd_oe, txd_out, remote_rxd;
  logic [31:0] rd;
  logic [7:0] b;
  logic [7:0] b2;
  logic ninth;
  logic [7:0] tx_cfg[5] = '{8'h01, 8'h12, 8'h03, 8'h07, 8'h27};
  logic [9:0] exp_q[$];
  int n_bits = 8;
  int bit_len = BIT_LEN;
  logic ext_clk = 1'b0;
  logic txd_prev = 1'b1;
  logic [7:0] sync_sh = 8'h00;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  // open drain in mode 0, pulled up otherwise
  wire rxd_line = rxd_oe ? 1'b0 : remote_rxd;

  serial_port_control DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
    .external_clock_input(ext_clk)
  );
  serial_remote_device u_remote (
    .clk(hclk), .txd(txd_out), .bit_len(bit_len), .n_bits(n_bits), .rxd(remote_rxd)
  );

  always #20 hclk = ~hclk;

  // external generator clock, eight bus cycles a period
  always begin
    repeat (4) @(posedge hclk);
    ext_clk <= ~ext_clk;
  end

  // mode 0 shift register on the far side: takes the data pin at each rising shift clock
  always @(posedge hclk) begin
    txd_prev <= txd_out;
    if (txd_out && !txd_prev) begin
      sync_sh <= {rxd_line, sync_sh[7:1]};
    end
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t ns: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_frame(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t ns: frame got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [15:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rd_check(input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(a, 1'b0, 32'h00000000);
    check_reg(rd & m, exp);
  endtask

  task automatic expect_frame();
    logic [9:0] g;
    int t;
    t = 0;
    g = 'x;
    while (u_remote.got_q.size() == 0 && t < 2000) begin
      @(posedge hclk);
      t++;
    end
    if (u_remote.got_q.size() != 0) g = 10'(u_remote.got_q.pop_front());
    check_frame(g, exp_q.pop_front());
  endtask

  initial begin
    void'($urandom(32'h427141EF));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_check(ADDR_STATUS, ALL, 32'h0000000B);
    rd_check(ADDR_CONFIG, ALL, 32'h00000000);
    rd_check(ADDR_BAUD, 32'hFFFF8000, 32'h00000000);
    bus(ADDR_BAUD, 1'b1, 32'h00008001);
    rd_check(ADDR_BAUD, 32'hFFFF8000, 32'h00008000);
    check_reg({31'h0, rd[14:0] <= 15'h0001}, 32'h00000001);
    $display("test reset and divider done");
    // parity stays off in mode 2
    foreach (tx_cfg[k]) begin
      b = 8'($urandom);
      n_bits = (tx_cfg[k][1:0] == 2'b01) ? 8 : 9;
      ninth = tx_cfg[k][2] ? (^b ^ tx_cfg[k][5]) : tx_cfg[k][4];
      exp_q.push_back((n_bits == 8) ? {2'b10, b} : {1'b1, ninth, b});
      bus(ADDR_CONFIG, 1'b1, {24'h0, tx_cfg[k]});
      bus(ADDR_TX_DATA, 1'b1, {24'h0, b});
      rd_check(ADDR_STATUS, ALL, 32'h00000003);
      expect_frame();
      repeat (BIT_LEN) @(posedge hclk);
      rd_check(ADDR_STATUS, ALL, 32'h0000002B);
      rd_check(ADDR_STATUS, ALL, 32'h0000000B);
      rd_check(ADDR_CONFIG, ALL, {24'h0, tx_cfg[k] & 8'hEF});
    end
    $display("test transmit modes done");
    bus(ADDR_CONFIG, 1'b1, 32'h00000009);
    b = 8'($urandom);
    u_remote.send_frame({1'b0, b}, 8, 1'b1);
    rd_check(ADDR_STATUS, ALL, 32'h0000004B);
    rd_check(ADDR_RX_DATA, ALL, {24'h0, b});
    b2 = 8'($urandom);
    u_remote.send_frame({1'b0, b}, 8, 1'b1);
    u_remote.send_frame({1'b0, b2}, 8, 1'b1);
    rd_check(ADDR_STATUS, ALL, 32'h0000004F);
    rd_check(ADDR_RX_DATA, ALL, {24'h0, b2});
    u_remote.send_frame({1'b0, b}, 8, 1'b0);
    rd_check(ADDR_STATUS, 32'h00000010, 32'h00000010);
    bus(ADDR_RX_DATA, 1'b0, 32'h00000000);
    $display("test receive done");
    bus(ADDR_CONFIG, 1'b1, 32'h0000000D);
    u_remote.send_frame({1'b0, ~^b[6:0], b[6:0]}, 8, 1'b1);
    rd_check(ADDR_STATUS, 32'h000000C0, 32'h000000C0);
    bus(ADDR_CONFIG, 1'b1, 32'h0000002D);
    u_remote.send_frame({1'b0, ~^b[6:0], b[6:0]}, 8, 1'b1);
    rd_check(ADDR_STATUS, 32'h000000C0, 32'h00000040);
    $display("test receive parity done");
    bus(ADDR_CONFIG, 1'b1, 32'h00000009);
    fork
      u_remote.send_frame({1'b0, b}, 8, 1'b1);
      begin
        repeat (3 * BIT_LEN) @(posedge hclk);
        bus(ADDR_CONFIG, 1'b1, 32'h00000001);
      end
    join
    rd_check(ADDR_STATUS, ALL, 32'h0000000B);
    $display("test receive disable done");
    n_bits = 8;
    bus(ADDR_TX_DATA, 1'b1, {24'h0, b});
    repeat (3 * BIT_LEN) @(posedge hclk);
    bus(ADDR_CONFIG, 1'b1, 32'h00000003);
    repeat (12 * BIT_LEN) @(posedge hclk);
    check_reg({31'h0, txd_out}, 32'h00000001);
    rd_check(ADDR_STATUS, ALL, 32'h0000000B);
    u_remote.got_q.delete();
    $display("test mode change abort done");
    // external source, divider 2: a bit is 16 external periods of 8 cycles
    bus(ADDR_BAUD, 1'b1, 32'h00000002);
    bus(ADDR_CONFIG, 1'b1, 32'h00000001);
    bit_len = 128;
    n_bits = 8;
    b = 8'($urandom);
    exp_q.push_back({2'b10, b});
    bus(ADDR_TX_DATA, 1'b1, {24'h0, b});
    expect_frame();
    repeat (bit_len) @(posedge hclk);
    rd_check(ADDR_STATUS, 32'h00000020, 32'h00000020);
    $display("test external clock done");
    bus(ADDR_BAUD, 1'b1, 32'h00008002);
    bus(ADDR_CONFIG, 1'b1, 32'h00000000);
    b2 = 8'($urandom);
    bus(ADDR_TX_DATA, 1'b1, {24'h0, b2});
    repeat (100) @(posedge hclk);
    check_reg({24'h0, sync_sh}, {24'h0, b2});
    rd_check(ADDR_STATUS, ALL, 32'h0000002B);
    u_remote.got_q.delete();
    $display("test mode 0 send done");
    stop_test();
  end
endmodule
